// file: hw/cmgy_top.sv
// cmgy_top: colour matrix, tone curve and rgb to luma/chroma conversion
// assumes a single 20 mhz clock, pixels from logic on the same clock,
// and an avalon-mm master that holds its request until waitrequest drops.
`timescale 1ns/1ns

module cmgy_top #(
  parameter int TONE_DEPTH = cmgy_pkg::TONE_DEPTH
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // avalon-mm register slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // pixel input
  input wire logic PIX_IN_VALID,
  input wire cmgy_pkg::cmgy_rgb_t PIX_IN,
  // pixel output
  output logic PIX_OUT_VALID,
  output cmgy_pkg::cmgy_ycc_t PIX_OUT
);

  localparam int P = cmgy_pkg::PIX_W;
  localparam logic [P-1:0] PMAX = {P{1'b1}};

  // register storage
  logic [11:0] ccm_q [9]; // rr gr br rg gg bg rb gb bb
  logic [13:0] off_q [3]; // r g b offsets
  logic [9:0] csc_q [9]; // ry gy by rcb gcb bcb rcr gcr bcr
  logic [15:0] tone_curve_config_q;
  logic [15:0] luma_contrast_brightness_q;
  logic [8:0] tone_addr_q; // writable table pointer
  logic [P-1:0] tone_ram [TONE_DEPTH]; // writable tone table
  logic [31:0] pix_count_q; // pixels delivered, status
  // bus handshake
  logic ack_q;
  logic [31:0] rdata_q;

  // clip a signed wide sum into the pixel range
  function automatic logic [P-1:0] clip(input logic signed [31:0] v);
    if (v < 0)
      clip = '0;
    else if (v > 32'(PMAX))
      clip = PMAX;
    else
      clip = v[P-1:0];
  endfunction : clip

  // fixed tone curve: square root shape approximated by two slopes
  function automatic logic [P-1:0] rom_curve(input logic [8:0] idx);
    logic [13:0] t;
    t = 14'h0000;
    if (idx < 9'h080)
      t = {idx[6:0], 7'h00} >> 0;
    else
      t = 14'(14'h3fff - ((14'(9'h1ff - idx)) << 4));
    rom_curve = t[13:2];
  endfunction : rom_curve

  // decode an address hit on one offset, for writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // waitrequest: low for exactly one cycle per request
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      ack_q <= 1'b0;
    else
      ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
  end

  // registered answer flag, so the bus never sees a combinational glitch
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
  end

  // a write lands on the edge that shows its answer
  logic wr_go;
  assign wr_go = AVS_WRITE && ack_q;

  // coefficient, offset and control registers, byte lanes 0 and 1 (tone configuration lane 0 only)
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int i = 0; i < 9; i++)
        ccm_q[i] <= (i % 4 == 0) ? cmgy_pkg::RST_CCM_DIAG
                                 : cmgy_pkg::RST_CCM_OFF;
      for (int i = 0; i < 3; i++)
        off_q[i] <= cmgy_pkg::RST_OFFSET;
      csc_q[0] <= cmgy_pkg::RST_CSC_RY;
      csc_q[1] <= cmgy_pkg::RST_CSC_GY;
      csc_q[2] <= cmgy_pkg::RST_CSC_BY;
      csc_q[3] <= cmgy_pkg::RST_CSC_RCB;
      csc_q[4] <= cmgy_pkg::RST_CSC_GCB;
      csc_q[5] <= cmgy_pkg::RST_CSC_BCB;
      csc_q[6] <= cmgy_pkg::RST_CSC_RCR;
      csc_q[7] <= cmgy_pkg::RST_CSC_GCR;
      csc_q[8] <= cmgy_pkg::RST_CSC_BCR;
      tone_curve_config_q <= cmgy_pkg::RST_TONE_CFG;
      luma_contrast_brightness_q <= cmgy_pkg::RST_LUMA_ADJ;
    end
    else if (wr_go)
    begin
      // matrix coefficients, low twelve bits kept
      for (int i = 0; i < 9; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_CCM_RR + 8'(4 * i))))
        begin
          if (AVS_BYTEENABLE[0])
            ccm_q[i][7:0] <= AVS_WRITEDATA[7:0];
          if (AVS_BYTEENABLE[1])
            ccm_q[i][11:8] <= AVS_WRITEDATA[11:8];
        end
      // channel offsets, low fourteen bits kept
      for (int i = 0; i < 3; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_OFF_R + 8'(4 * i))))
        begin
          if (AVS_BYTEENABLE[0])
            off_q[i][7:0] <= AVS_WRITEDATA[7:0];
          if (AVS_BYTEENABLE[1])
            off_q[i][13:8] <= AVS_WRITEDATA[13:8];
        end
      // conversion coefficients, low ten bits kept
      for (int i = 0; i < 9; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_CSC_RY + 8'(4 * i))))
        begin
          if (AVS_BYTEENABLE[0])
            csc_q[i][7:0] <= AVS_WRITEDATA[7:0];
          if (AVS_BYTEENABLE[1])
            csc_q[i][9:8] <= AVS_WRITEDATA[9:8];
        end
      // tone configuration: reserved bits stay zero
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_CFG) && AVS_BYTEENABLE[0])
        tone_curve_config_q <= {9'h000, AVS_WRITEDATA[6:4], 1'b0,
                                AVS_WRITEDATA[2:0]};
      // luma gain in low byte, lift in high byte
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_LUMA_ADJ))
      begin
        if (AVS_BYTEENABLE[0])
          luma_contrast_brightness_q[7:0] <= AVS_WRITEDATA[7:0];
        if (AVS_BYTEENABLE[1])
          luma_contrast_brightness_q[15:8] <= AVS_WRITEDATA[15:8];
      end
    end
  end

  // writable table pointer, steps after each data write
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      tone_addr_q <= 9'h000;
    else if (wr_go && hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_ADDR))
      tone_addr_q <= AVS_WRITEDATA[8:0];
    else if (wr_go && hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_DATA))
      tone_addr_q <= 9'(tone_addr_q + 9'h001);
  end

  // writable table storage, no reset
  always_ff @(posedge CLOCK)
  begin
    if (wr_go && hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_DATA))
      tone_ram[tone_addr_q] <= AVS_WRITEDATA[P-1:0];
  end

  // read mux, registered in the taking cycle
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      rdata_q <= 32'h0000_0000;
    else if (AVS_READ && !ack_q)
    begin
      rdata_q <= 32'h0000_0000; // unmapped reads as zero
      for (int i = 0; i < 9; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_CCM_RR + 8'(4 * i))))
          rdata_q <= {20'h00000, ccm_q[i]};
      for (int i = 0; i < 3; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_OFF_R + 8'(4 * i))))
          rdata_q <= {18'h00000, off_q[i]};
      for (int i = 0; i < 9; i++)
        if (hit(AVS_ADDRESS, 8'(cmgy_pkg::OFS_CSC_RY + 8'(4 * i))))
          rdata_q <= {22'h000000, csc_q[i]};
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_CFG))
        rdata_q <= {16'h0000, tone_curve_config_q};
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_LUMA_ADJ))
        rdata_q <= {16'h0000, luma_contrast_brightness_q};
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_ADDR))
        rdata_q <= {23'h000000, tone_addr_q};
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_TONE_DATA))
        rdata_q <= {20'h00000, tone_ram[tone_addr_q]};
      if (hit(AVS_ADDRESS, cmgy_pkg::OFS_STATUS))
        rdata_q <= pix_count_q;
    end
  end

  // read data straight from its register
  assign AVS_READDATA = rdata_q;

  // stage 1: colour matrix with offsets and clip
  logic v1_q;
  cmgy_pkg::cmgy_rgb_t p1_q;
  logic [P-1:0] ch_in [3];
  logic [P-1:0] ch_mat [3];
  assign ch_in[0] = PIX_IN.r;
  assign ch_in[1] = PIX_IN.g;
  assign ch_in[2] = PIX_IN.b;

  // one loop variable shared by the three per-channel loops
  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_ccm
      logic signed [31:0] acc;
      always_comb
      begin
        acc = 32'sd0;
        for (int k = 0; k < 3; k++)
          acc = acc + $signed({20'h00000, ch_in[k]}) *
                $signed({{20{ccm_q[gc * 3 + k][11]}}, ccm_q[gc * 3 + k]});
        acc = (acc >>> cmgy_pkg::FRAC) +
              $signed({{18{off_q[gc][13]}}, off_q[gc]});
        ch_mat[gc] = clip(acc);
      end
    end
  endgenerate

  // stage 1 register: valid follows the input by one edge
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      v1_q <= 1'b0;
      p1_q <= '0;
    end
    else
    begin
      v1_q <= PIX_IN_VALID;
      p1_q <= {ch_mat[0], ch_mat[1], ch_mat[2]};
    end
  end

  // stage 2: tone lookup per channel
  logic v2_q;
  cmgy_pkg::cmgy_rgb_t p2_q;
  logic [P-1:0] ch1 [3];
  logic [P-1:0] ch_tone [3];
  logic [1:0] len_code;
  assign ch1[0] = p1_q.r;
  assign ch1[1] = p1_q.g;
  assign ch1[2] = p1_q.b;
  assign len_code = tone_curve_config_q[cmgy_pkg::CFG_LEN_LO +: 2];

  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_tone
      logic [8:0] idx;
      always_comb
      begin
        // index width follows table length; reserved code acts as 512
        case (len_code)
          cmgy_pkg::LEN_128: idx = {2'h0, ch1[gc][P-1 -: 7]};
          cmgy_pkg::LEN_256: idx = {1'h0, ch1[gc][P-1 -: 8]};
          default: idx = ch1[gc][P-1 -: 9];
        endcase
        if (tone_curve_config_q[gc])
          ch_tone[gc] = ch1[gc];
        else if (tone_curve_config_q[cmgy_pkg::CFG_SRC])
          ch_tone[gc] = rom_curve(idx);
        else
          ch_tone[gc] = tone_ram[idx];
      end
    end
  endgenerate

  // stage 2 register: tone result and its valid
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      v2_q <= 1'b0;
      p2_q <= '0;
    end
    else
    begin
      v2_q <= v1_q;
      p2_q <= {ch_tone[0], ch_tone[1], ch_tone[2]};
    end
  end

  // stage 3: conversion matrix, contrast and brightness
  logic [P-1:0] ch2 [3];
  logic [P-1:0] ycc [3];
  logic signed [31:0] yadj;
  assign ch2[0] = p2_q.r;
  assign ch2[1] = p2_q.g;
  assign ch2[2] = p2_q.b;

  // chroma channels are centred on mid scale, luma is not
  generate
    for (gc = 0; gc < 3; gc++)
    begin : g_csc
      logic signed [31:0] acc;
      always_comb
      begin
        acc = 32'sd0;
        for (int k = 0; k < 3; k++)
          acc = acc + $signed({20'h00000, ch2[k]}) *
                $signed({{22{csc_q[gc * 3 + k][9]}},
                         csc_q[gc * 3 + k]});
        acc = acc >>> cmgy_pkg::FRAC;
        if (gc != 0)
          acc = acc + $signed({20'h00000, cmgy_pkg::CHROMA_MID});
        ycc[gc] = clip(acc);
      end
    end
  endgenerate

  // luma gain then lift, lift scaled to the pixel width
  always_comb
  begin
    yadj = $signed({20'h00000, ycc[0]}) *
           $signed({24'h000000, luma_contrast_brightness_q[7:0]});
    yadj = (yadj >>> cmgy_pkg::GAIN_FRAC) +
           $signed({20'h00000,
                    luma_contrast_brightness_q[15:8], 4'h0});
  end

  // output register: every pixel output comes from a flip-flop
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      PIX_OUT_VALID <= 1'b0;
      PIX_OUT <= '0;
    end
    else
    begin
      PIX_OUT_VALID <= v2_q;
      PIX_OUT <= {clip(yadj), ycc[1], ycc[2]};
    end
  end

  // delivered pixel counter for status
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      pix_count_q <= 32'h0000_0000;
    else if (v2_q)
      pix_count_q <= 32'(pix_count_q + 32'h0000_0001);
  end

endmodule : cmgy_top

// file: hw/cmgy_pkg.sv
// cmgy_pkg: register map, field layout, reset values and pixel carriers
// for the colour matrix / tone curve / luma conversion stage.
// assumes a 32-bit avalon-mm register bus with one register per word.
package cmgy_pkg;

  // pixel width in and out of every stage
  localparam int PIX_W = 12;

  // register byte offsets (one aligned word each)
  localparam logic [7:0] OFS_CCM_RR = 8'h00;
  localparam logic [7:0] OFS_CCM_GR = 8'h04;
  localparam logic [7:0] OFS_CCM_BR = 8'h08;
  localparam logic [7:0] OFS_CCM_RG = 8'h0c;
  localparam logic [7:0] OFS_CCM_GG = 8'h10;
  localparam logic [7:0] OFS_CCM_BG = 8'h14;
  localparam logic [7:0] OFS_CCM_RB = 8'h18;
  localparam logic [7:0] OFS_CCM_GB = 8'h1c;
  localparam logic [7:0] OFS_CCM_BB = 8'h20;
  localparam logic [7:0] OFS_OFF_R = 8'h24;
  localparam logic [7:0] OFS_OFF_G = 8'h28;
  localparam logic [7:0] OFS_OFF_B = 8'h2c;
  localparam logic [7:0] OFS_TONE_CFG = 8'h30;
  localparam logic [7:0] OFS_LUMA_ADJ = 8'h34;
  localparam logic [7:0] OFS_CSC_RY = 8'h38;
  localparam logic [7:0] OFS_CSC_GY = 8'h3c;
  localparam logic [7:0] OFS_CSC_BY = 8'h40;
  localparam logic [7:0] OFS_CSC_RCB = 8'h44;
  localparam logic [7:0] OFS_CSC_GCB = 8'h48;
  localparam logic [7:0] OFS_CSC_BCB = 8'h4c;
  localparam logic [7:0] OFS_CSC_RCR = 8'h50;
  localparam logic [7:0] OFS_CSC_GCR = 8'h54;
  localparam logic [7:0] OFS_CSC_BCR = 8'h58;
  localparam logic [7:0] OFS_TONE_ADDR = 8'h5c;
  localparam logic [7:0] OFS_TONE_DATA = 8'h60;
  localparam logic [7:0] OFS_STATUS = 8'h64;

  // field widths and positions
  localparam int CCM_W = 12;
  localparam int OFF_W = 14;
  localparam int CSC_W = 10;
  localparam int FRAC = 8;
  localparam int GAIN_FRAC = 4;
  localparam int CFG_SKIP_R = 0;
  localparam int CFG_SKIP_G = 1;
  localparam int CFG_SKIP_B = 2;
  localparam int CFG_SRC = 4;
  localparam int CFG_LEN_LO = 5;
  localparam int ADJ_GAIN_LO = 0;
  localparam int ADJ_LIFT_LO = 8;

  // table length codes
  localparam logic [1:0] LEN_128 = 2'h0;
  localparam logic [1:0] LEN_256 = 2'h1;
  localparam logic [1:0] LEN_512 = 2'h3;
  localparam int TONE_DEPTH = 512;

  // reset values
  localparam logic [11:0] RST_CCM_DIAG = 12'h100;
  localparam logic [11:0] RST_CCM_OFF = 12'h000;
  localparam logic [13:0] RST_OFFSET = 14'h0000;
  localparam logic [15:0] RST_TONE_CFG = 16'h0067;
  localparam logic [15:0] RST_LUMA_ADJ = 16'h0010;
  localparam logic [9:0] RST_CSC_RY = 10'h04d;
  localparam logic [9:0] RST_CSC_GY = 10'h096;
  localparam logic [9:0] RST_CSC_BY = 10'h01d;
  localparam logic [9:0] RST_CSC_RCB = 10'h3d5;
  localparam logic [9:0] RST_CSC_GCB = 10'h3ab;
  localparam logic [9:0] RST_CSC_BCB = 10'h080;
  localparam logic [9:0] RST_CSC_RCR = 10'h080;
  localparam logic [9:0] RST_CSC_GCR = 10'h395;
  localparam logic [9:0] RST_CSC_BCR = 10'h3eb;
  localparam logic [PIX_W-1:0] CHROMA_MID = 12'h800;

  // pixel carriers
  typedef struct packed {
    logic [PIX_W-1:0] r;
    logic [PIX_W-1:0] g;
    logic [PIX_W-1:0] b;
  } cmgy_rgb_t;

  typedef struct packed {
    logic [PIX_W-1:0] y;
    logic [PIX_W-1:0] cb;
    logic [PIX_W-1:0] cr;
  } cmgy_ycc_t;

endpackage : cmgy_pkg

// file: testbench/cmgy_chk.sv
// cmgy_chk: bus handshake, reserved bits and pixel timing checks
// assumes it is bound to cmgy_top and sees only its ports
`timescale 1ns/1ns
module cmgy_chk #(
  parameter int TONE_DEPTH = 512
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic NRST,
  // register bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // pixel stream
  input wire logic PIX_IN_VALID,
  input wire logic PIX_OUT_VALID
);
  // one domain, reset aborts every check
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // a read answered in this cycle
  wire rd_ack = AVS_READ && !AVS_WAITREQUEST;

  AST_ACK_LATENCY: assert property (
    ($rose(AVS_READ) || $rose(AVS_WRITE)) |=> !AVS_WAITREQUEST)
    else $error("request not answered");
  AST_ACK_SINGLE: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (
    !AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
    else $error("answer without request");
  AST_RD_HOLD: assert property (
    !$stable(AVS_READDATA) |-> rd_ack)
    else $error("read data moved outside a read");
  AST_CCM_RSV: assert property (
    rd_ack && AVS_ADDRESS <= cmgy_pkg::OFS_CCM_BB
    |-> AVS_READDATA[31:12] == '0) else $error("matrix spare bits");
  AST_OFF_RSV: assert property (
    rd_ack && AVS_ADDRESS >= cmgy_pkg::OFS_OFF_R
    && AVS_ADDRESS <= cmgy_pkg::OFS_OFF_B |-> AVS_READDATA[31:14] == '0)
    else $error("offset spare bits");
  AST_CFG_RSV: assert property (
    rd_ack && AVS_ADDRESS == cmgy_pkg::OFS_TONE_CFG
    |-> AVS_READDATA[31:7] == '0 && !AVS_READDATA[3])
    else $error("tone config spare bits");
  AST_CSC_RSV: assert property (
    rd_ack && AVS_ADDRESS >= cmgy_pkg::OFS_CSC_RY
    && AVS_ADDRESS <= cmgy_pkg::OFS_CSC_BCR |-> AVS_READDATA[31:10] == '0)
    else $error("conversion spare bits");
  AST_PIX_LAT: assert property (
    PIX_IN_VALID |-> ##3 PIX_OUT_VALID)
    else $error("pixel not out after three cycles");
  AST_PIX_CAUSE: assert property (
    PIX_OUT_VALID |-> $past(PIX_IN_VALID, 3))
    else $error("pixel out without input");
endmodule : cmgy_chk

bind cmgy_top cmgy_chk #(.TONE_DEPTH(TONE_DEPTH)) i_chk (
  .CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIX_IN_VALID(PIX_IN_VALID),
  .PIX_OUT_VALID(PIX_OUT_VALID));

// file: testbench/cmgy_pix_model.sv
// cmgy_pix_model: upstream pixel source and downstream pixel sink
// assumes the bench queues pixels in tx and reads results from rx
`timescale 1ns/1ns
module cmgy_pix_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // towards the stage input
  output logic valid,
  output cmgy_pkg::cmgy_rgb_t pix,
  // from the stage output
  input wire logic out_valid,
  input wire cmgy_pkg::cmgy_ycc_t out
);
  // pixels waiting, results seen
  cmgy_pkg::cmgy_rgb_t tx[$];
  cmgy_pkg::cmgy_ycc_t rx[$];
  // one pixel a cycle; idle data toggles so stale values never match
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      valid <= 1'b0;
      pix <= '0;
    end
    else if (tx.size() > 0)
    begin
      valid <= 1'b1;
      pix <= tx.pop_front();
    end
    else
    begin
      valid <= 1'b0;
      pix <= ~pix;
    end
  end
  // collect every flagged result
  always @(posedge clock)
  begin
    if (out_valid === 1'b1)
      rx.push_back(out);
  end
endmodule : cmgy_pix_model

// file: testbench/cmgy_tb.sv
// cmgy_tb: register and pixel tests of the colour stage
// assumes cmgy_pkg, cmgy_top, the checker and the pixel model
`timescale 1ns/1ns
module testbench;
  // bus, clock and stream signals
  logic clock, nrst, rd, wr, wait_req, in_valid, out_valid;
  logic [3:0] be;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, q;
  cmgy_pkg::cmgy_rgb_t pix_in;
  cmgy_pkg::cmgy_ycc_t pix_out;
  int n_errors = 0;
  int check_count = 0;
  int i;
  // last pixel result, and pixels sent so far
  cmgy_pkg::cmgy_ycc_t got;
  int n_pix = 0;
  // reset value of each word from 0x00
  logic [15:0] rst_v [23] = '{'h100, 0, 0, 0, 'h100, 0, 0, 0, 'h100, 0, 0,
    0, 'h67, 'h10, 'h4d, 'h96, 'h1d, 'h3d5, 'h3ab, 'h80, 'h80, 'h395, 'h3eb};

  cmgy_top #(.TONE_DEPTH(512)) i_dut (.CLOCK(clock), .NRST(nrst),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
    .PIX_IN_VALID(in_valid), .PIX_IN(pix_in), .PIX_OUT_VALID(out_valid),
    .PIX_OUT(pix_out));
  cmgy_pix_model i_pix (.clock(clock), .nrst(nrst), .valid(in_valid),
    .pix(pix_in), .out_valid(out_valid), .out(pix_out));

  // writable bits of each word
  function automatic logic [15:0] msk(input int k);
    return (k < 9) ? 16'hfff : (k < 12) ? 16'h3fff : (k == 12) ? 16'h77 :
      (k == 13) ? 16'hffff : 16'h3ff;
  endfunction : msk

  // compare and count
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one bus access, held until waitrequest samples low
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    // no local limit: only the watchdog ends a wait
    while (wait_req !== 1'b0)
      @(posedge clock);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  // one pixel through, result compared under a mask
  task px(input logic [35:0] in, input logic [35:0] e,
    input logic [35:0] m = '1);
    int n;
    n = 0;
    n_pix++;
    @(negedge clock);
    i_pix.tx.push_back(in);
    while (i_pix.rx.size() == 0 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    // a pixel that never comes counts as a mismatch
    if (n == 20)
      n_errors++;
    else
      got = i_pix.rx.pop_front();
    chk(got & m, e & m);
  endtask : px

  // verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge clock);
    n_errors++;
    complete_run();
  end

  // test sequence
  initial
  begin
    {nrst, rd, wr, addr, wdata} = '0;
    be = 4'hf;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // reset values, then writable bits of the 23 words from 0x00 to 0x58
    for (i = 0; i < 23; i++)
    begin
      av(0, 8'(i * 4), 0);
      chk(q, rst_v[i]);
      av(1, 8'(i * 4), '1);
      av(0, 8'(i * 4), 0);
      chk(q, msk(i));
      av(1, 8'(i * 4), rst_v[i]);
    end
    // unmapped word, and config write without lane 0
    av(1, 8'h7c, '1);
    av(0, 8'h7c, 0);
    chk(q, 0);
    be <= 4'he;
    av(1, cmgy_pkg::OFS_TONE_CFG, 0);
    be <= 4'hf;
    av(0, cmgy_pkg::OFS_TONE_CFG, 0);
    chk(q, 'h67);
    // defaults pass gray and pure red
    px({3{12'h123}}, {12'h123, 24'h800800});
    px({12'h100, 24'h0}, {36'h04d7d5880});
    // y follows red alone, chroma flat
    av(1, cmgy_pkg::OFS_CSC_RY, 'h100);
    av(1, cmgy_pkg::OFS_CSC_GY, 0);
    for (i = 16; i < 23; i++)
      av(1, 8'(i * 4), 0);
    av(1, cmgy_pkg::OFS_CCM_GR, 'h080);
    px({36'h100200000}, {12'h200, 24'h800800});
    av(1, cmgy_pkg::OFS_CCM_GR, 'hf80);
    px({36'h100400000}, {12'h000, 24'h800800});
    av(1, cmgy_pkg::OFS_CCM_GR, 0);
    av(1, cmgy_pkg::OFS_OFF_R, 'h3f00);
    px({12'h300, 24'h0}, {12'h200, 24'h800800});
    av(1, cmgy_pkg::OFS_OFF_R, 'hfff);
    px({12'h800, 24'h0}, {12'hfff, 24'h800800});
    av(1, cmgy_pkg::OFS_OFF_R, 0);
    av(1, cmgy_pkg::OFS_LUMA_ADJ, 'h20);
    px({12'h300, 24'h0}, {12'h600, 24'h800800});
    av(1, cmgy_pkg::OFS_LUMA_ADJ, 'h510);
    px({12'h300, 24'h0}, {12'h350, 24'h800800});
    av(1, cmgy_pkg::OFS_LUMA_ADJ, 'h10);
    // falling table, red through it at each length
    av(1, cmgy_pkg::OFS_TONE_ADDR, 0);
    for (i = 0; i < 512; i++)
      av(1, cmgy_pkg::OFS_TONE_DATA, 32'(4095 - i));
    for (i = 0; i < 4; i++)
    begin
      av(1, cmgy_pkg::OFS_TONE_CFG, 32'((i << 5) | 6));
      px({12'h300, 24'h0}, {12'(4095 - (12'h300 >> ((i == 0) ? 5 :
        (i == 1) ? 4 : 3))), 24'h800800});
    end
    // fixed table must not follow the writable one
    av(1, cmgy_pkg::OFS_TONE_CFG, 'h76);
    px({12'h300, 24'h0}, {12'h0, 24'h800800}, {12'h0, 24'hffffff});
    chk(got.y == 12'hf9f, 1'b0);
    av(1, cmgy_pkg::OFS_TONE_CFG, 'h61);
    px({12'h300, 24'h0}, {12'h300, 24'h800800});
    // pointer wrapped after 512 writes; table and pixel count read back
    av(0, cmgy_pkg::OFS_TONE_ADDR, 0);
    chk(q, 0);
    av(1, cmgy_pkg::OFS_TONE_ADDR, 5);
    av(0, cmgy_pkg::OFS_TONE_DATA, 0);
    chk(q, 4090);
    av(0, cmgy_pkg::OFS_STATUS, 0);
    chk(q, n_pix);
    complete_run();
  end
endmodule : testbench
